// ===== bench/converter_status_flags_props.sv
// Checker: port timing relations of the converter event status bank.
// Assumes it is bound to converter_status_flags and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module converter_status_flags_props #(
  parameter int CHANNELS = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [status_flags_pkg::ADDR_W-1:0] addr_i,
  input wire logic [status_flags_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [status_flags_pkg::DATA_W-1:0] rdata_o,
  input wire status_flags_pkg::device_events_type events_i,
  input wire status_flags_pkg::launch_writes_type launches_i,
  input wire logic [status_flags_pkg::DATA_W-1:0] event_status_o,
  input wire logic interrupt_out_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic stat_rd = rd_i && addr_i == 7'h38;

  a_spare_bits_zero: assert property (event_status_o[6:4] == 3'h0)
    else $error("spare status bits not zero");
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 24'h0)
    else $error("read data outside read cycle");
  a_read_shows_flags: assert property (stat_rd |=> rdata_o == $past(event_status_o))
    else $error("status read data wrong");
  a_read_clears_all: assert property (
    stat_rd && events_i == '0 |=> event_status_o == 24'h0)
    else $error("status read did not clear");
  a_conv_flag_set: assert property (events_i.conv_result |=> event_status_o[0])
    else $error("conversion flag not set");
  a_over_flag_set: assert property (events_i.chan_over[7] |=> event_status_o[23])
    else $error("over-range flag not set");
  a_under_flag_set: assert property (events_i.chan_under[0] |=> event_status_o[8])
    else $error("under-range flag not set");
  a_gain_flag_set: assert property (events_i.gain_cal_fault |=> event_status_o[7])
    else $error("gain fault flag not set");
  a_wait_launch_clear: assert property (
    launches_i.wait_launch_reg && !events_i.wait_done |=> !event_status_o[3])
    else $error("wait flag not cleared");
  a_cal_launch_clear: assert property (
    launches_i.cal_launch_reg && !events_i.cal_done |=> !event_status_o[2])
    else $error("calibration flag not cleared");
  a_conv_launch_clear: assert property (
    launches_i.conversion_launch_reg && !events_i.conv_result |=> !event_status_o[0])
    else $error("conversion flag not cleared");
  a_seq_launch_clear: assert property (
    launches_i.sequence_launch_reg && !events_i.seq_iteration |=> !event_status_o[1])
    else $error("sequence flag not cleared");
  a_seq_wrap_clear: assert property (
    events_i.seq_wrap && !events_i.seq_iteration |=> !event_status_o[1])
    else $error("sequence flag survived wrap");
  a_irq_has_cause: assert property (!interrupt_out_n_o |-> event_status_o != 24'h0)
    else $error("interrupt without a flag");
endmodule

`default_nettype wire

// ===== bench/status_host.sv
// Host model: drives the register port with one-cycle strobes.
// Assumes the read data stand only in the cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none

module status_host (
  input wire logic clock_i,
  input wire logic [23:0] rdata_i,
  output logic [6:0] addr_o,
  output logic [23:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 7'h00;
    wdata_o = 24'h000000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic write_reg(input logic [6:0] a, input logic [23:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    // Released data shows the inverse so a stale value never looks valid
    wdata_o <= ~d;
  endtask

  task automatic read_reg(input logic [6:0] a, output logic [23:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule

`default_nettype wire

// ===== bench/test_converter_status_flags.sv
// Testbench: drives device events and host register traffic.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/100ps
`default_nettype none

module test_converter_status_flags;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  status_flags_pkg::device_events_type events_i = '0;
  status_flags_pkg::launch_writes_type launches_i = '0;
  logic [6:0] addr_i;
  logic [23:0] wdata_i, rdata_o, event_status_o;
  logic wr_i, rd_i, interrupt_out_n_o;
  int fails = 0;
  int checks = 0;
  logic [23:0] ev_t [3] = '{24'h000040, 24'h000020, 24'h000010};
  logic [23:0] st_t [3] = '{24'h000008, 24'h000004, 24'h000001};
  logic [3:0] ln_t [3] = '{4'h2, 4'h1, 4'h4};

  always #5 clock_i = ~clock_i;

  converter_status_flags #(.CHANNELS(8)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .events_i(events_i), .launches_i(launches_i), .event_status_o(event_status_o),
    .interrupt_out_n_o(interrupt_out_n_o));
  status_host host (.clock_i(clock_i), .rdata_i(rdata_o), .addr_o(addr_i),
    .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic expect_rd(input logic [6:0] a, input logic [23:0] e);
    logic [23:0] v;
    host.read_reg(a, v);
    chk("rdata", v, e);
  endtask

  task automatic pulse(input logic [23:0] e, input logic [3:0] l);
    @(posedge clock_i);
    events_i <= e;
    launches_i <= l;
    @(posedge clock_i);
    events_i <= '0;
    launches_i <= '0;
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    #1 chk("irq", 24'(interrupt_out_n_o), 24'h000001);
    expect_rd(status_flags_pkg::ENABLE_ADDR, 24'h000001);
    expect_rd(7'h38, 24'h000000);
    expect_rd(7'h00, 24'h000000);
    for (int n = 0; n < 8; n++) begin
      pulse((24'h000001 << (16 + n)) | (24'h000001 << (15 - n)), 4'h0);
      expect_rd(7'h38, (24'h000001 << (16 + n)) | (24'h000001 << (15 - n)));
      expect_rd(7'h38, 24'h000000);
    end
    pulse(24'h0000C0, 4'h0);
    host.write_reg(7'h38, 24'hFFFFFF);
    host.write_reg(status_flags_pkg::CLEAR_ADDR, 24'h000008);
    expect_rd(7'h38, 24'h000080);
    expect_rd(7'h38, 24'h000000);
    pulse(24'h000010, 4'h0);
    chk("irq", 24'(interrupt_out_n_o), 24'h000000);
    host.write_reg(status_flags_pkg::ENABLE_ADDR, 24'h000000);
    #1 chk("irq", 24'(interrupt_out_n_o), 24'h000001);
    host.write_reg(status_flags_pkg::ENABLE_ADDR, 24'hFFFFFF);
    expect_rd(status_flags_pkg::ENABLE_ADDR, 24'hFFFF8F);
    chk("irq", 24'(interrupt_out_n_o), 24'h000000);
    expect_rd(7'h38, 24'h000001);
    chk("irq", 24'(interrupt_out_n_o), 24'h000001);
    for (int i = 0; i < 3; i++) begin
      pulse(ev_t[i], 4'h0);
      chk("status", event_status_o, st_t[i]);
      pulse(24'h000000, ln_t[i]);
      expect_rd(7'h38, 24'h000000);
    end
    // Iteration while no sequence runs must be ignored
    pulse(24'h000004, 4'h0);
    expect_rd(7'h38, 24'h000000);
    pulse(24'h000000, 4'h8);
    pulse(24'h000004, 4'h0);
    expect_rd(7'h38, 24'h000002);
    pulse(24'h000004, 4'h0);
    chk("status", event_status_o, 24'h000002);
    pulse(24'h000002, 4'h0);
    expect_rd(7'h38, 24'h000000);
    pulse(24'h000004, 4'h0);
    pulse(24'h000000, 4'h8);
    expect_rd(7'h38, 24'h000000);
    host.write_reg(status_flags_pkg::CONTROL_ADDR, 24'hFFFFFF);
    expect_rd(status_flags_pkg::CONTROL_ADDR, 24'h000001);
    pulse(24'h000010, 4'h0);
    chk("status", event_status_o, 24'h000001);
    pulse(24'h000008, 4'h0);
    expect_rd(7'h38, 24'h000000);
    // A read that meets a new result still leaves the flag set
    fork
      pulse(24'h000010, 4'h0);
      expect_rd(7'h38, 24'h000000);
    join
    chk("status", event_status_o, 24'h000001);
    // After a halt the tracker is idle again, so an iteration is dropped
    pulse(24'h000001, 4'h0);
    pulse(24'h000004, 4'h0);
    expect_rd(7'h38, 24'h000001);
    // Reset in mid-run restores the enable and control words
    pulse(24'h000010, 4'h0);
    chk("irq", 24'(interrupt_out_n_o), 24'h000000);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    #1 chk("irq", 24'(interrupt_out_n_o), 24'h000001);
    expect_rd(status_flags_pkg::CONTROL_ADDR, 24'h000000);
    expect_rd(status_flags_pkg::ENABLE_ADDR, 24'h000001);
    expect_rd(7'h38, 24'h000000);
    report_and_stop();
  end

  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule

bind converter_status_flags converter_status_flags_props #(.CHANNELS(CHANNELS)) props (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .events_i(events_i), .launches_i(launches_i),
  .event_status_o(event_status_o), .interrupt_out_n_o(interrupt_out_n_o));

`default_nettype wire

// ===== hdl/converter_status_flags.sv
// Event status bank of a multi-channel converter: sticky flags, their
// interrupt enables and the read-to-clear register port.
// Assumes event and launch-write pulses come from logic on clock_i and
// that the host port issues one-cycle strobes, never both at once.
//
// Function
// RULE_01 - Sequence flag set after one full iteration
// RULE_02 - Sequence flag cleared: read, launch, wraparound
// RULE_03 - Conversion flag set on new result
// RULE_04 - Conversion flag cleared: read, launch, pre-result
// RULE_05 - Per-channel over-range flags at bits 23:16
// RULE_06 - Per-channel under-range flags at bits 15:8
// RULE_07 - Gain calibration fault flag, read clears
// RULE_08 - Wait flag set on finish, cleared
// RULE_09 - Calibration flag set on coefficients, cleared
// RULE_10 - Bits 6 to 4 read zero
// RULE_11 - Interrupt ORs enabled flags; conversion enabled
// RULE_12 - Status register lives at address 0x38
`timescale 1ns/100ps
`default_nettype none

module converter_status_flags #(
  parameter int CHANNELS = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [status_flags_pkg::ADDR_W-1:0] addr_i,
  input wire logic [status_flags_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [status_flags_pkg::DATA_W-1:0] rdata_o,
  input wire status_flags_pkg::device_events_type events_i,
  input wire status_flags_pkg::launch_writes_type launches_i,
  output logic [status_flags_pkg::DATA_W-1:0] event_status_o,
  output logic interrupt_out_n_o
);

  localparam int DW = status_flags_pkg::DATA_W;
  localparam int MC = status_flags_pkg::MAX_CHANNELS;

  initial begin
    if (CHANNELS < 1 || CHANNELS > MC) begin
      $error("converter_status_flags: CHANNELS must be 1 to 8");
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic sel_status;
  logic sel_enable;
  logic sel_clear;
  logic sel_control;
  logic status_read;
  logic enable_write;
  logic clear_write;
  logic control_write;

  assign sel_status = (addr_i == status_flags_pkg::STATUS_ADDR); // RULE_12
  assign sel_enable = (addr_i == status_flags_pkg::ENABLE_ADDR);
  assign sel_clear = (addr_i == status_flags_pkg::CLEAR_ADDR);
  assign sel_control = (addr_i == status_flags_pkg::CONTROL_ADDR);
  assign status_read = rd_i & sel_status;
  assign enable_write = wr_i & sel_enable;
  assign clear_write = wr_i & sel_clear;
  assign control_write = wr_i & sel_control;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Bit 0 selects continuous (1) or duty-cycle (0) conversion; in continuous
  // mode each new result first wipes the previous conversion flag.
  logic [DW-1:0] control_d;
  logic [DW-1:0] control_q;
  logic cont_mode;

  assign control_d = control_write ? (wdata_i & status_flags_pkg::CONTROL_BITS)
                                   : control_q;
  assign cont_mode = control_q[status_flags_pkg::CONT_MODE_BIT];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      control_q <= status_flags_pkg::CONTROL_RESET;
    end else begin
      control_q <= control_d;
    end
  end

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  logic [DW-1:0] enable_d;
  logic [DW-1:0] enable_q;

  assign enable_d = enable_write ? (wdata_i & status_flags_pkg::USED_BITS)
                                 : enable_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      enable_q <= status_flags_pkg::ENABLE_RESET; // RULE_11
    end else begin
      enable_q <= enable_d;
    end
  end

  // ----------------------------------------------------------------
  // Sequence tracker
  // ----------------------------------------------------------------
  // Only a sequence that was launched can report an iteration; a stray
  // iteration pulse while idle is ignored.
  status_flags_pkg::seq_state_type seq_state_d;
  status_flags_pkg::seq_state_type seq_state_q;

  always_comb begin
    seq_state_d = seq_state_q;
    case (seq_state_q)
      status_flags_pkg::seq_idle: begin
        if (launches_i.sequence_launch_reg) begin
          seq_state_d = status_flags_pkg::seq_run;
        end
      end
      status_flags_pkg::seq_run: begin
        if (events_i.seq_halt && !launches_i.sequence_launch_reg) begin
          seq_state_d = status_flags_pkg::seq_idle;
        end
      end
      default: begin
        seq_state_d = status_flags_pkg::seq_idle;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seq_state_q <= status_flags_pkg::seq_idle;
    end else begin
      seq_state_q <= seq_state_d;
    end
  end

  logic seq_set;
  logic seq_clear;

  assign seq_set = events_i.seq_iteration
                   & (seq_state_q == status_flags_pkg::seq_run); // RULE_01
  assign seq_clear = launches_i.sequence_launch_reg
                     | events_i.seq_wrap; // RULE_02

  // ----------------------------------------------------------------
  // Per-flag set and clear terms
  // ----------------------------------------------------------------
  logic [MC-1:0] chan_keep;
  logic conv_clear;
  logic wait_clear;
  logic cal_clear;
  logic [DW-1:0] set_vec;
  logic [DW-1:0] own_clear;
  logic [DW-1:0] clear_vec;
  logic [DW-1:0] flags;

  assign chan_keep = MC'((1 << CHANNELS) - 1);

  assign conv_clear = launches_i.conversion_launch_reg
                      | (cont_mode & events_i.conv_pre_result); // RULE_04
  assign wait_clear = launches_i.wait_launch_reg; // RULE_08
  assign cal_clear = launches_i.cal_launch_reg; // RULE_09

  assign set_vec = {events_i.chan_over & chan_keep, // RULE_05
                    events_i.chan_under & chan_keep, // RULE_06
                    events_i.gain_cal_fault, // RULE_07
                    3'h0, // RULE_10
                    events_i.wait_done, // RULE_08
                    events_i.cal_done, // RULE_09
                    seq_set,
                    events_i.conv_result}; // RULE_03

  assign own_clear = {{(DW - 4){1'b0}}, wait_clear, cal_clear, seq_clear,
                      conv_clear};

  // A status read clears every flag; the clear word clears its ones
  assign clear_vec = {DW{status_read}} // RULE_05 RULE_06 RULE_07
                     | (clear_write ? wdata_i : '0)
                     | own_clear;

  sticky_flag_array #(
    .WIDTH(DW)
  ) u_flags (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .set_i(set_vec),
    .clear_i(clear_vec),
    .flags_o(flags)
  );

  // ----------------------------------------------------------------
  // Status view and interrupt
  // ----------------------------------------------------------------
  logic [DW-1:0] status_view;
  logic [DW-1:0] flags_next;
  logic int_n_d;
  logic int_n_q;
  logic [DW-1:0] status_out_q;

  assign status_view = flags & status_flags_pkg::USED_BITS; // RULE_10

  // Interrupt is computed from the next flag and enable values so the
  // pin moves in the same cycle as the flags it reflects.
  assign flags_next = (set_vec | (flags & ~clear_vec))
                      & status_flags_pkg::USED_BITS;
  assign int_n_d = ~|(flags_next & enable_d); // RULE_11

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      int_n_q <= 1'b1;
      status_out_q <= '0;
    end else begin
      int_n_q <= int_n_d;
      status_out_q <= flags_next;
    end
  end

  assign interrupt_out_n_o = int_n_q;
  assign event_status_o = status_out_q;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data show the flags as they stood before the read cleared them.
  status_read_port #(
    .DATA_W(DW)
  ) u_read (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .rd_i(rd_i),
    .sel_status_i(sel_status),
    .sel_enable_i(sel_enable),
    .sel_control_i(sel_control),
    .status_i(status_view), // RULE_12
    .enable_i(enable_q),
    .control_i(control_q),
    .rdata_o(rdata_o)
  );

endmodule

`default_nettype wire

// ===== hdl/status_flags_pkg.sv
// Package: register map, field layout and carrier types of the
// converter event status bank.
// Assumes one 24-bit register word per address on a 7-bit address port.
package status_flags_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 24;
  localparam int MAX_CHANNELS = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 7'h38;
  localparam logic [ADDR_W-1:0] ENABLE_ADDR = 7'h39;
  localparam logic [ADDR_W-1:0] CLEAR_ADDR = 7'h50;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = 7'h51;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CONV_BIT = 0;
  localparam int SEQ_BIT = 1;
  localparam int CAL_BIT = 2;
  localparam int WAIT_BIT = 3;
  localparam int GAIN_BIT = 7;
  localparam int UNDER_LSB = 8;
  localparam int OVER_LSB = 16;
  localparam int CONT_MODE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ENABLE_RESET = 24'h000001;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] USED_BITS = 24'hFFFF8F;
  localparam logic [DATA_W-1:0] CONTROL_BITS = 24'h000001;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MAX_CHANNELS-1:0] chan_over;
    logic [MAX_CHANNELS-1:0] chan_under;
    logic gain_cal_fault;
    logic wait_done;
    logic cal_done;
    logic conv_result;
    logic conv_pre_result;
    logic seq_iteration;
    logic seq_wrap;
    logic seq_halt;
  } device_events_type;

  typedef struct packed {
    logic sequence_launch_reg;
    logic conversion_launch_reg;
    logic wait_launch_reg;
    logic cal_launch_reg;
  } launch_writes_type;

  typedef enum logic [1:0] {
    seq_idle = 2'b01,
    seq_run = 2'b10
  } seq_state_type;

endpackage

// ===== hdl/status_read_port.sv
// Registered read-data port: selects one register word per read strobe.
// Assumes the select lines are one-hot or all low; unmapped reads give 0.
`timescale 1ns/100ps
`default_nettype none

module status_read_port #(
  parameter int DATA_W = 24
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic sel_status_i,
  input wire logic sel_enable_i,
  input wire logic sel_control_i,
  input wire logic [DATA_W-1:0] status_i,
  input wire logic [DATA_W-1:0] enable_i,
  input wire logic [DATA_W-1:0] control_i,
  output logic [DATA_W-1:0] rdata_o
);

  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;

  // Data stand for one cycle only, so a stale word is never mistaken
  assign rdata_d = rd_i ? (({DATA_W{sel_status_i}} & status_i)
                         | ({DATA_W{sel_enable_i}} & enable_i)
                         | ({DATA_W{sel_control_i}} & control_i))
                        : '0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule

`default_nettype wire

// ===== hdl/sticky_flag_array.sv
// Sticky flag array: one flag per bit, set has priority over clear.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module sticky_flag_array #(
  parameter int WIDTH = 24
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clear_i,
  output logic [WIDTH-1:0] flags_o
);

  initial begin
    if (WIDTH < 1) begin
      $error("sticky_flag_array: WIDTH must be at least 1");
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_flag
    logic flag_d;
    logic flag_q;
    // An event in the clearing cycle survives the clear
    assign flag_d = set_i[i] | (flag_q & ~clear_i[i]);
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        flag_q <= 1'b0;
      end else begin
        flag_q <= flag_d;
      end
    end
    assign flags_o[i] = flag_q;
  end

endmodule

`default_nettype wire
